//--- hw/tmz_pkg.sv
// Purpose: Shared constants for the eight-bit timer with shared prescaler.
// Assumes: Byte-wide register port with an eight-bit address.
// Notes: Offsets, field positions, reset values and timing counts live here.

package tmz_pkg;

	// ==========================================================
	// Register offsets
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_TIMER_COUNT = 8'h01;
	localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h0b;
	localparam logic [7:0] OFS_OPTION_CONFIG = 8'h81;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h90;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h91;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h92;

	// ==========================================================
	// Field positions
	localparam int unsigned OPT_SRC_BIT = 5;
	localparam int unsigned OPT_EDGE_BIT = 4;
	localparam int unsigned OPT_ASSIGN_BIT = 3;
	localparam int unsigned OPT_RATIO_LSB = 0;
	localparam int unsigned RATIO_W = 3;
	localparam int unsigned ICTL_IE_BIT = 5;
	localparam int unsigned ICTL_FLAG_BIT = 2;
	localparam int unsigned IRQ_OVF_BIT = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] TIMER_COUNT_RST = 8'h00;
	localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
	localparam logic [7:0] OPTION_CONFIG_RST = 8'hff;

	// ==========================================================
	// Timing
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [1:0] WR_INHIBIT_CYCLES = 2'h2;

	// Four clock phases make one instruction cycle.
	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} tmz_phase_t;

endpackage : tmz_pkg

//--- hw/tmz_sync.sv
// Purpose: Two-flop synchroniser for levels from outside the clock domain.
// Assumes: Input is a slowly changing level.
// Notes: Only the second flop is visible to other logic.

`timescale 1ns/1ps
`default_nettype none

module tmz_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Data
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta <= '0;
			o_sync <= '0;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end

endmodule : tmz_sync

`default_nettype wire

//--- hw/tmz_prescaler.sv
// Purpose: Shared prescaler counter with timer and watchdog taps.
// Assumes: Ticks are one-cycle pulses on the module clock.
// Notes: Timer side divides by 2^(ratio+1), watchdog side by 2^ratio.

`timescale 1ns/1ps
`default_nettype none

module tmz_prescaler #(
	parameter int unsigned W = 8,
	parameter int unsigned RW = 3
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_clear,
	input wire logic i_tick,
	input wire logic [RW-1:0] i_ratio,
	// Taps
	output logic [W-1:0] o_count,
	output logic o_tap,
	output logic o_wrap_timer,
	output logic o_wrap_wdt
);

	wire logic [RW:0] tshift = {1'b0, i_ratio} + {{RW{1'b0}}, 1'b1};
	wire logic [W:0] span_t = ({{W{1'b0}}, 1'b1} << tshift) - {{W{1'b0}}, 1'b1};
	wire logic [W:0] span_w = ({{W{1'b0}}, 1'b1} << i_ratio) - {{W{1'b0}}, 1'b1};
	wire logic [W-1:0] mask_t = span_t[W-1:0];
	wire logic [W-1:0] mask_w = span_w[W-1:0];

	assign o_tap = o_count[i_ratio];
	assign o_wrap_timer = i_tick && ((o_count & mask_t) == mask_t);
	assign o_wrap_wdt = i_tick && ((o_count & mask_w) == mask_w);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_count <= '0;
		end else if (i_clear) begin
			o_count <= '0;
		end else if (i_tick) begin
			o_count <= o_count + {{(W-1){1'b0}}, 1'b1};
		end
	end

endmodule : tmz_prescaler

`default_nettype wire

//--- hw/tmz_timer.sv
// Purpose: Eight-bit timer/counter with a prescaler shared with the watchdog.
// Assumes: Four clock phases per instruction cycle; sleep and watchdog
//          clear come from core logic on the same clock.
// Notes: Registers sit on a plain strobe port with read data one cycle late.
// Function
// - Timer mode: count once per instruction cycle, after prescaling.
// - A count write holds off counting for two instruction cycles.
// - Counter mode: count selected edges of the external count pin.
// - Edge select clear means rising edges, set means falling edges.
// - Rollover from maximum to zero sets the overflow flag.
// - Overflow flag raises the interrupt only while its enable is set.
// - Flag stays set until software clears it before re-enabling.
// - Timer stops during sleep, so no overflow or wake-up then.
// - External count synchronised by sampling prescaler output on Q2 and Q4.
// - One prescaler serves either timer or watchdog; the other runs undivided.
// - Prescaler count is never readable or writable by software.
// - Assignment bit and three-bit ratio sit in option register low bits.
// - Count writes clear the prescaler when it serves the timer.
// - Watchdog clear clears the prescaler when it serves the watchdog.
//
// Added by the designer: the strobed register port.

`timescale 1ns/1ps
`default_nettype none

module tmz_timer #(
	parameter int unsigned PSC_W = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// External count pin
	input wire logic i_ext_count,
	// Core and watchdog
	input wire logic i_sleep,
	input wire logic i_wdt_clear,
	input wire logic i_wdt_osc_tick,
	output logic o_wdt_tick,
	// Interrupt
	output logic o_irq
);

	// ==========================================================
	// Phase clocks
	tmz_pkg::tmz_phase_t phase;
	wire logic q2 = (phase == tmz_pkg::PH_Q2);
	wire logic q4 = (phase == tmz_pkg::PH_Q4);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			phase <= tmz_pkg::PH_Q1;
		end else begin
			unique case (phase)
				tmz_pkg::PH_Q1: phase <= tmz_pkg::PH_Q2;
				tmz_pkg::PH_Q2: phase <= tmz_pkg::PH_Q3;
				tmz_pkg::PH_Q3: phase <= tmz_pkg::PH_Q4;
				tmz_pkg::PH_Q4: phase <= tmz_pkg::PH_Q1;
			endcase
		end
	end

	// ==========================================================
	// Registers and decode
	logic [7:0] timer_count;
	logic [7:0] option_config;
	logic [7:0] ictl_rest;
	logic overflow_flag;
	logic [1:0] inhibit;

	wire logic wr_tmr = i_wr && (i_addr == tmz_pkg::OFS_TIMER_COUNT);
	wire logic wr_ictl = i_wr && (i_addr == tmz_pkg::OFS_INTERRUPT_CONTROL);
	wire logic wr_opt = i_wr && (i_addr == tmz_pkg::OFS_OPTION_CONFIG);
	wire logic wr_clr = i_wr && (i_addr == tmz_pkg::OFS_IRQ_CLEAR);
	wire logic wr_en = i_wr && (i_addr == tmz_pkg::OFS_IRQ_ENABLE);

	// Option and interrupt-control fields steering the block.
	wire logic timer_source_select = option_config[tmz_pkg::OPT_SRC_BIT];
	wire logic external_edge_select = option_config[tmz_pkg::OPT_EDGE_BIT];
	wire logic prescaler_assignment = option_config[tmz_pkg::OPT_ASSIGN_BIT];
	wire logic [tmz_pkg::RATIO_W-1:0] prescale_ratio_field =
		option_config[tmz_pkg::OPT_RATIO_LSB +: tmz_pkg::RATIO_W];
	wire logic overflow_interrupt_enable = ictl_rest[tmz_pkg::ICTL_IE_BIT];
	wire logic psc_to_timer = !prescaler_assignment;

	// ==========================================================
	// External input conditioning
	logic pin_sync;
	logic pin_prev;
	logic samp;

	tmz_sync #(
		.W(1)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_ext_count),
		.o_sync(pin_sync)
	);

	// Inverting for falling-edge mode lets one rising detector serve both.
	wire logic pin_lvl = pin_sync ^ external_edge_select;
	wire logic pin_rise = pin_lvl && !pin_prev;

	// ==========================================================
	// Shared prescaler
	logic [PSC_W-1:0] psc_cnt;
	logic psc_tap;
	logic wrap_timer;
	logic wrap_wdt;

	wire logic tmr_src = timer_source_select ? pin_rise : q4;
	// The watchdog keeps its own time base through sleep.
	wire logic psc_tick = prescaler_assignment ? i_wdt_osc_tick :
		(!i_sleep && tmr_src);
	wire logic psc_clr = prescaler_assignment ? i_wdt_clear : wr_tmr;

	tmz_prescaler #(
		.W(PSC_W),
		.RW(tmz_pkg::RATIO_W)
	) u_psc (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clear(psc_clr),
		.i_tick(psc_tick),
		.i_ratio(prescale_ratio_field),
		.o_count(psc_cnt),
		.o_tap(psc_tap),
		.o_wrap_timer(wrap_timer),
		.o_wrap_wdt(wrap_wdt)
	);

	// ==========================================================
	// Increment selection
	// Without the prescaler the conditioned pin stands in for its output.
	wire logic ext_src = psc_to_timer ? psc_tap : pin_lvl;
	wire logic sample_now = q2 || q4;
	wire logic ext_inc = sample_now && ext_src && !samp;
	wire logic int_inc = q4 && (prescaler_assignment || wrap_timer);
	wire logic raw_inc = !i_sleep && (timer_source_select ? ext_inc : int_inc);
	wire logic count_en = raw_inc && (inhibit == 2'h0) && !wr_tmr;
	// Low prescaler bits that must read zero right after a timer-side wrap.
	wire logic [3:0] div_shift = {1'b0, prescale_ratio_field} + 4'h1;
	wire logic [PSC_W:0] div_span =
		({{PSC_W{1'b0}}, 1'b1} << div_shift) - {{PSC_W{1'b0}}, 1'b1};
	wire logic [PSC_W-1:0] div_mask = div_span[PSC_W-1:0];
	wire logic ovf_ev = count_en && (timer_count == tmz_pkg::COUNT_MAX);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			// The option reset value selects falling edges, so the idle pin reads high here.
			pin_prev <= 1'b1;
			samp <= 1'b1;
		end else begin
			pin_prev <= pin_lvl;
			if (sample_now) begin
				samp <= ext_src;
			end
		end
	end

	// ==========================================================
	// Count register and write hold-off
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			timer_count <= tmz_pkg::TIMER_COUNT_RST;
			inhibit <= 2'h0;
		end else if (wr_tmr) begin
			timer_count <= i_wdata;
			inhibit <= tmz_pkg::WR_INHIBIT_CYCLES;
		end else begin
			if (count_en) begin
				timer_count <= timer_count + 8'h01;
			end
			if (q4 && (inhibit != 2'h0)) begin
				inhibit <= inhibit - 2'h1;
			end
		end
	end

	// ==========================================================
	// Option and interrupt control
	wire logic [7:0] ictl_wmask = ~(8'h01 << tmz_pkg::ICTL_FLAG_BIT);
	wire logic sw_clear = wr_clr && i_wdata[tmz_pkg::IRQ_OVF_BIT];
	wire logic next_flag_sw = wr_ictl ? i_wdata[tmz_pkg::ICTL_FLAG_BIT] :
		(overflow_flag && !sw_clear);
	// A rollover in the cycle of a clear still leaves the flag set.
	wire logic next_flag = ovf_ev || next_flag_sw;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			option_config <= tmz_pkg::OPTION_CONFIG_RST;
			ictl_rest <= tmz_pkg::INTERRUPT_CONTROL_RST;
			overflow_flag <= 1'b0;
		end else begin
			overflow_flag <= next_flag;
			if (wr_opt) begin
				option_config <= i_wdata;
			end
			if (wr_ictl) begin
				ictl_rest <= i_wdata & ictl_wmask;
			end else if (wr_en) begin
				ictl_rest[tmz_pkg::ICTL_IE_BIT] <= i_wdata[tmz_pkg::IRQ_OVF_BIT];
			end
		end
	end

	assign o_irq = overflow_flag && overflow_interrupt_enable;

	// ==========================================================
	// Watchdog time base
	// Unassigned, the watchdog sees its raw oscillator ticks.
	wire logic next_wdt_tick = prescaler_assignment ? wrap_wdt : i_wdt_osc_tick;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wdt_tick <= 1'b0;
		end else begin
			o_wdt_tick <= next_wdt_tick;
		end
	end

	// ==========================================================
	// Read path
	// The prescaler has no address, so its count never reaches the bus.
	wire logic [7:0] ictl_view = ictl_rest | ({7'h00, overflow_flag} << tmz_pkg::ICTL_FLAG_BIT);
	wire logic [7:0] stat_view = {7'h00, overflow_flag};
	wire logic [7:0] en_view = {7'h00, overflow_interrupt_enable};
	wire logic [7:0] rd_mux =
		(i_addr == tmz_pkg::OFS_TIMER_COUNT) ? timer_count :
		(i_addr == tmz_pkg::OFS_INTERRUPT_CONTROL) ? ictl_view :
		(i_addr == tmz_pkg::OFS_OPTION_CONFIG) ? option_config :
		(i_addr == tmz_pkg::OFS_IRQ_STATUS) ? stat_view :
		(i_addr == tmz_pkg::OFS_IRQ_ENABLE) ? en_view : 8'h00;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rd_mux : 8'h00;
		end
	end

	// ==========================================================
	// Assertions
	a_timer_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(!timer_source_select && prescaler_assignment && q4 && !i_sleep &&
		inhibit == 2'h0 && !wr_tmr) |=> timer_count == $past(timer_count) + 8'h01)
		else $error("timer did not step on instruction cycle");

	a_write_holdoff: assert property (@(posedge i_clk) disable iff (i_rst)
		wr_tmr ##1 (!wr_tmr) [*4] |-> $stable(timer_count))
		else $error("count changed right after a write");

	a_ext_phase: assert property (@(posedge i_clk) disable iff (i_rst)
		(count_en && timer_source_select) |-> (q2 || q4))
		else $error("external count outside Q2 or Q4");

	a_ext_edge: assert property (@(posedge i_clk) disable iff (i_rst)
		(count_en && timer_source_select && prescaler_assignment) |->
		(pin_lvl && !$past(pin_lvl, 3)) || $past(pin_lvl) || $past(pin_lvl, 2))
		else $error("external count without selected edge");

	a_ovf_sets: assert property (@(posedge i_clk) disable iff (i_rst)
		ovf_ev |=> overflow_flag && timer_count == 8'h00)
		else $error("rollover did not set flag");

	a_irq_gate: assert property (@(posedge i_clk) disable iff (i_rst)
		!overflow_interrupt_enable |-> !o_irq)
		else $error("interrupt while disabled");

	a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
		(overflow_flag && !wr_ictl && !wr_clr) |=> overflow_flag)
		else $error("flag dropped without software");

	a_sleep_stop: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_sleep && !wr_tmr) |=> $stable(timer_count) && !overflow_flag ||
		$past(overflow_flag) || $past(wr_ictl))
		else $error("timer moved during sleep");

	a_wdt_direct: assert property (@(posedge i_clk) disable iff (i_rst)
		(!prescaler_assignment && !$past(prescaler_assignment)) |->
		o_wdt_tick == $past(i_wdt_osc_tick))
		else $error("watchdog divided while prescaler on timer");

	a_psc_clr_tmr: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_tmr && psc_to_timer) |=> psc_cnt == '0 && $stable(option_config))
		else $error("count write did not clear prescaler");

	a_psc_clr_wdt: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wdt_clear && prescaler_assignment) |=> psc_cnt == '0)
		else $error("watchdog clear did not clear prescaler");

	a_div_ratio: assert property (@(posedge i_clk) disable iff (i_rst)
		(psc_to_timer && !timer_source_select && int_inc && !i_sleep) |=>
		(psc_cnt & div_mask) == '0 || $past(psc_clr) || $past(wr_opt))
		else $error("prescaler wrap not at ratio");

	c_overflow: cover property (@(posedge i_clk) disable iff (i_rst) ovf_ev && o_irq == 1'b0);
	c_ext_count: cover property (@(posedge i_clk) disable iff (i_rst)
		count_en && timer_source_select && external_edge_select);
	c_wdt_div: cover property (@(posedge i_clk) disable iff (i_rst)
		prescaler_assignment && o_wdt_tick);
	c_clear_race: cover property (@(posedge i_clk) disable iff (i_rst) ovf_ev && sw_clear);

endmodule : tmz_timer

`default_nettype wire

//--- dv/tmz_pulse_src.sv
// Purpose: Count pin source that makes a burst of level changes.
// Assumes: Runs on the bench clock; the pin keeps its last driven level.
// Notes: Each level is held for a programmable number of clocks.

`timescale 1ns/1ps
`default_nettype none

module tmz_pulse_src (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Burst request
	input wire logic i_go,
	input wire logic [7:0] i_n,
	input wire logic [7:0] i_hold,
	// Pin
	output logic o_pin,
	output logic o_busy
);
	logic [7:0] left;
	logic [7:0] cnt;

	// ==========================================================
	// Burst engine
	// Holding each level four clocks or more outlasts two sampling phases.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pin <= 1'b0;
			o_busy <= 1'b0;
			left <= 8'h00;
			cnt <= 8'h00;
		end else if (!o_busy && i_go) begin
			left <= i_n;
			cnt <= i_hold;
			o_busy <= (i_n != 8'h00);
		end else if (o_busy && cnt == 8'h01) begin
			o_pin <= ~o_pin;
			left <= left - 8'h01;
			cnt <= i_hold;
			o_busy <= (left != 8'h01);
		end else if (o_busy) begin
			cnt <= cnt - 8'h01;
		end
	end
endmodule : tmz_pulse_src

`default_nettype wire

//--- dv/test_tmz_timer.sv
// Purpose: Self-checking bench for the eight-bit timer with shared prescaler.
// Assumes: Four clocks per instruction cycle; a partner drives the count pin.
// Notes: Seeded random values are mixed with fixed corner cases.

`timescale 1ns/1ps
`default_nettype none

module test_tmz_timer;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_sleep = 1'b0;
	logic i_wdt_clear = 1'b0;
	logic i_wdt_osc_tick = 1'b0;
	logic p_go = 1'b0;
	logic [7:0] p_n = 8'h00;
	logic [7:0] p_hold = 8'h04;
	logic [7:0] o_rdata;
	logic o_wdt_tick;
	logic o_irq;
	logic pin;
	logic p_busy;
	logic [7:0] v;
	logic [7:0] a;
	logic [7:0] b;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_wt = 0;
	int lvl = 0;
	int n;
	int d;

	tmz_timer tmz_timer_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_ext_count(pin), .i_sleep(i_sleep), .i_wdt_clear(i_wdt_clear),
		.i_wdt_osc_tick(i_wdt_osc_tick), .o_wdt_tick(o_wdt_tick), .o_irq(o_irq));
	tmz_pulse_src tmz_pulse_src_inst (.i_clk(i_clk), .i_rst(i_rst), .i_go(p_go),
		.i_n(p_n), .i_hold(p_hold), .o_pin(pin), .o_busy(p_busy));

	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) if (o_wdt_tick === 1'b1) n_wt++;

	// ==========================================================
	// Bus and check tasks
	task automatic waitc(input int c);
		repeat (c) @(posedge i_clk);
		#1;
	endtask : waitc

	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge i_clk);
		i_addr <= ad;
		i_wdata <= dt;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
		@(posedge i_clk);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		dt = o_rdata;
	endtask : rd

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
		logic [7:0] t;
		rd(ad, t);
		chk(t, exp);
	endtask : rchk

	task automatic osc(input int k);
		repeat (k) begin
			@(posedge i_clk);
			i_wdt_osc_tick <= 1'b1;
			@(posedge i_clk);
			i_wdt_osc_tick <= 1'b0;
		end
	endtask : osc

	task automatic stop_test;
		$display("counts: %0d mismatches, %0d compares", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	// ==========================================================
	// Expectations
	function automatic logic [7:0] edges(input int s, input int k, input int f);
		return ((s ^ f) != 0) ? 8'(k / 2) : 8'((k + 1) / 2);
	endfunction : edges

	function automatic logic [7:0] incs(input int r, input int span);
		return 8'(span / (4 << (r + 1)));
	endfunction : incs

	initial begin
		waitc(40000);
		n_mismatch++;
		$display("FAIL %0t timeout", $time);
		stop_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h534e));
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		rchk(tmz_pkg::OFS_OPTION_CONFIG, tmz_pkg::OPTION_CONFIG_RST);
		rchk(tmz_pkg::OFS_INTERRUPT_CONTROL, tmz_pkg::INTERRUPT_CONTROL_RST);
		rchk(8'h55, 8'h00);
		rchk(tmz_pkg::OFS_IRQ_CLEAR, 8'h00);
		$display("test regs done");
		// Undivided timer mode: the prescaler stays with the watchdog.
		wr(tmz_pkg::OFS_OPTION_CONFIG, 8'h08);
		waitc(12);
		rd(tmz_pkg::OFS_TIMER_COUNT, a);
		waitc(38);
		rd(tmz_pkg::OFS_TIMER_COUNT, b);
		chk(b - a, 8'h0a);
		// A read two edges after a write must still see the written value.
		repeat (6) begin
			waitc($urandom % 4);
			v = 8'($urandom % 200);
			wr(tmz_pkg::OFS_TIMER_COUNT, v);
			rchk(tmz_pkg::OFS_TIMER_COUNT, v);
		end
		$display("test timer done");
		wr(tmz_pkg::OFS_INTERRUPT_CONTROL, 8'h20);
		wr(tmz_pkg::OFS_TIMER_COUNT, 8'hfd);
		waitc(40);
		chk({7'h00, o_irq}, 8'h01);
		rchk(tmz_pkg::OFS_IRQ_STATUS, 8'h01);
		wr(tmz_pkg::OFS_IRQ_ENABLE, 8'h00);
		waitc(1);
		chk({7'h00, o_irq}, 8'h00);
		rchk(tmz_pkg::OFS_INTERRUPT_CONTROL, 8'h04);
		wr(tmz_pkg::OFS_IRQ_ENABLE, 8'h01);
		waitc(1);
		chk({7'h00, o_irq}, 8'h01);
		wr(tmz_pkg::OFS_IRQ_CLEAR, 8'h01);
		waitc(1);
		chk({7'h00, o_irq}, 8'h00);
		rchk(tmz_pkg::OFS_IRQ_STATUS, 8'h00);
		$display("test irq done");
		wr(tmz_pkg::OFS_TIMER_COUNT, 8'hf0);
		waitc(12);
		i_sleep <= 1'b1;
		rd(tmz_pkg::OFS_TIMER_COUNT, a);
		waitc(100);
		rchk(tmz_pkg::OFS_TIMER_COUNT, a);
		rchk(tmz_pkg::OFS_IRQ_STATUS, 8'h00);
		i_sleep <= 1'b0;
		$display("test sleep done");
		// Every ratio code with the prescaler on the timer, over four steps.
		for (int r = 0; r < 8; r++) begin
			d = 32 << r;
			wr(tmz_pkg::OFS_OPTION_CONFIG, 8'(r));
			wr(tmz_pkg::OFS_TIMER_COUNT, 8'h00);
			waitc(12);
			rd(tmz_pkg::OFS_TIMER_COUNT, a);
			waitc(d - 2);
			rd(tmz_pkg::OFS_TIMER_COUNT, b);
			chk(b - a, incs(r, d));
		end
		// A second count write restarts the 1:256 prescaler from zero.
		waitc(600);
		wr(tmz_pkg::OFS_TIMER_COUNT, 8'h00);
		waitc(800);
		rchk(tmz_pkg::OFS_TIMER_COUNT, 8'h00);
		waitc(400);
		rchk(tmz_pkg::OFS_TIMER_COUNT, 8'h01);
		$display("test prescaler done");
		wr(tmz_pkg::OFS_OPTION_CONFIG, 8'h00);
		waitc(1);
		n_wt = 0;
		osc(10);
		waitc(4);
		chk(8'(n_wt), 8'h0a);
		wr(tmz_pkg::OFS_TIMER_COUNT, 8'h00);
		wr(tmz_pkg::OFS_OPTION_CONFIG, 8'h0a);
		// Two ticks leave the prescaler off a multiple of four unless the clear works.
		osc(2);
		@(posedge i_clk);
		i_wdt_clear <= 1'b1;
		@(posedge i_clk);
		i_wdt_clear <= 1'b0;
		waitc(1);
		n_wt = 0;
		osc(14);
		waitc(4);
		chk(8'(n_wt), 8'(14 >> 2));
		$display("test watchdog done");
		// Counter mode without prescaler, rising and falling edges in turn.
		for (int i = 0; i < 4; i++) begin
			wr(tmz_pkg::OFS_OPTION_CONFIG, 8'h28 | 8'((i % 2) << 4));
			waitc(12);
			wr(tmz_pkg::OFS_TIMER_COUNT, 8'h00);
			waitc(12);
			n = 1 + $urandom % 15;
			p_n <= 8'(n);
			p_hold <= 8'(4 + $urandom % 4);
			@(posedge i_clk);
			p_go <= 1'b1;
			@(posedge i_clk);
			p_go <= 1'b0;
			waitc(1);
			for (int t = 0; t < 400 && p_busy === 1'b1; t++) @(posedge i_clk);
			waitc(20);
			rchk(tmz_pkg::OFS_TIMER_COUNT, edges(lvl, n, i % 2));
			lvl = lvl ^ (n & 1);
		end
		$display("test counter done");
		stop_test();
	end
endmodule : test_tmz_timer

`default_nettype wire
